// ### rtl/pdma_channel.sv
`timescale 1ns/1ps
module pdma_channel
  import pdma_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] wr_i,
  input wire logic [31:0] wdata_i,
  input wire logic done_i,
  output logic [31:0] pointer_o,
  output logic [15:0] count_o,
  output logic [31:0] next_pointer_o,
  output logic [15:0] next_count_o,
  output logic end_o,
  output logic empty_o
);
  // wr_i: 0 pointer, 1 count, 2 next pointer, 3 next count
  logic [31:0] ptr_reg, ptr_next, nptr_reg, nptr_next;
  logic [15:0] cnt_reg, cnt_next, ncnt_reg, ncnt_next;
  logic end_reg, end_next, empty_reg, empty_next;

  always_comb begin
    ptr_next = ptr_reg;
    cnt_next = cnt_reg;
    nptr_next = nptr_reg;
    ncnt_next = ncnt_reg;
    end_next = 1'b0;
    empty_next = 1'b0;
    if (done_i && cnt_reg != RST_COUNT) begin
      ptr_next = ptr_reg + XFER_SIZE; // see R11
      cnt_next = cnt_reg - 16'h0001; // see R11
    end
    if (wr_i[0]) ptr_next = wdata_i; // see R4
    if (wr_i[1]) cnt_next = wdata_i[15:0]; // see R5
    if (wr_i[2]) nptr_next = wdata_i; // see R6
    if (wr_i[3]) ncnt_next = wdata_i[15:0]; // see R7
    if (cnt_next == RST_COUNT && ncnt_next != RST_COUNT && !wr_i[1]) begin
      ptr_next = nptr_next; // see R12
      cnt_next = ncnt_next; // see R12
      ncnt_next = RST_COUNT; // see R12
    end
    if (done_i && cnt_reg == 16'h0001) begin
      end_next = 1'b1;
      empty_next = (ncnt_reg == RST_COUNT) && !wr_i[3];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_reg <= RST_POINTER;
      cnt_reg <= RST_COUNT;
      nptr_reg <= RST_POINTER;
      ncnt_reg <= RST_COUNT;
      end_reg <= 1'b0;
      empty_reg <= 1'b0;
    end else begin
      ptr_reg <= ptr_next;
      cnt_reg <= cnt_next;
      nptr_reg <= nptr_next;
      ncnt_reg <= ncnt_next;
      end_reg <= end_next;
      empty_reg <= empty_next;
    end
  end

  assign pointer_o = ptr_reg;
  assign count_o = cnt_reg;
  assign next_pointer_o = nptr_reg;
  assign next_count_o = ncnt_reg;
  assign end_o = end_reg;
  assign empty_o = empty_reg;
endmodule

// ### rtl/pdma_pair.sv
`timescale 1ns/1ps
// Behaviour
// R1: moves words between serial peripheral and memory without processor help.
// R2: one pair of channels, dedicated to one peripheral.
// R3: channel 0 is receive (peripheral to memory), channel 1 is transmit.
// R4: each channel has a software-written 32-bit current memory pointer.
// R5: each channel has a software-written 16-bit current transfer count.
// R6: each channel has a 32-bit next memory pointer for a queued buffer.
// R7: each channel has a 16-bit next transfer count for a queued buffer.
// R8: peripheral asks for each single transfer with its tx or rx request.
// R9: peripheral raises end-of-transfer interrupt once programmed data moved.
// R10: channel registers sit from offset 0x100 in the peripheral space.
// R11: each transfer advances pointer by size, decrements count; idle at zero.
// R12: at zero count with queued buffer, load next into current, clear next; code clears only the next count, next pointer keeps its value.
module pdma_pair
  import pdma_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // peripheral side
  input wire logic rx_req_i,
  input wire logic [31:0] rx_data_i,
  output logic rx_ack_o,
  input wire logic tx_req_i,
  output logic [31:0] tx_data_o,
  output logic tx_valid_o,
  output logic end_rx_o,
  output logic end_tx_o,
  // memory master (classic single cycle)
  output logic mem_cyc_o,
  output logic mem_we_o,
  output logic [31:0] mem_adr_o,
  output logic [31:0] mem_dat_o,
  input wire logic [31:0] mem_dat_i,
  input wire logic mem_ack_i,
  output logic irq_o
);
  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  logic req, wr_stb, ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next, wmask;
  logic [31:0] rx_ptr, rx_nptr, tx_ptr, tx_nptr;
  logic [15:0] rx_cnt, rx_ncnt, tx_cnt, tx_ncnt;
  logic [1:0] ctl_reg, ctl_next;
  logic [IRQ_W-1:0] ist_reg, ist_next, imask_reg, imask_next, ev;
  logic [3:0] rx_wr, tx_wr;
  logic rx_end, tx_end, rx_empty, tx_empty;

  assign req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_stb = req && wb_we_i;
  // only full words are meaningful for pointers; byte lanes merge with old value
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  always_comb begin
    rx_wr = 4'h0;
    tx_wr = 4'h0;
    if (wr_stb) begin
      case (wb_adr_i) // see R10
        OFF_RX_POINTER: rx_wr[0] = 1'b1;
        OFF_RX_COUNT: rx_wr[1] = 1'b1;
        OFF_RX_NEXT_POINTER: rx_wr[2] = 1'b1;
        OFF_RX_NEXT_COUNT: rx_wr[3] = 1'b1;
        OFF_TX_POINTER: tx_wr[0] = 1'b1;
        OFF_TX_COUNT: tx_wr[1] = 1'b1;
        OFF_TX_NEXT_POINTER: tx_wr[2] = 1'b1;
        OFF_TX_NEXT_COUNT: tx_wr[3] = 1'b1;
        default: begin
          rx_wr = 4'h0;
          tx_wr = 4'h0;
        end
      endcase
    end
  end

  logic [31:0] wsel;
  always_comb begin
    case (wb_adr_i)
      OFF_RX_POINTER: wsel = merge(rx_ptr, wb_dat_i, wmask);
      OFF_RX_COUNT: wsel = merge({16'h0000, rx_cnt}, wb_dat_i, wmask);
      OFF_RX_NEXT_POINTER: wsel = merge(rx_nptr, wb_dat_i, wmask);
      OFF_RX_NEXT_COUNT: wsel = merge({16'h0000, rx_ncnt}, wb_dat_i, wmask);
      OFF_TX_POINTER: wsel = merge(tx_ptr, wb_dat_i, wmask);
      OFF_TX_COUNT: wsel = merge({16'h0000, tx_cnt}, wb_dat_i, wmask);
      OFF_TX_NEXT_POINTER: wsel = merge(tx_nptr, wb_dat_i, wmask);
      OFF_TX_NEXT_COUNT: wsel = merge({16'h0000, tx_ncnt}, wb_dat_i, wmask);
      default: wsel = wb_dat_i;
    endcase
  end

  // ------------------------------------------------------------
  // channels
  // ------------------------------------------------------------
  logic rx_done, tx_done;

  pdma_channel u_rx ( // see R2
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(rx_wr),
    .wdata_i(wsel),
    .done_i(rx_done),
    .pointer_o(rx_ptr),
    .count_o(rx_cnt),
    .next_pointer_o(rx_nptr),
    .next_count_o(rx_ncnt),
    .end_o(rx_end),
    .empty_o(rx_empty)
  );

  pdma_channel u_tx ( // see R3
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(tx_wr),
    .wdata_i(wsel),
    .done_i(tx_done),
    .pointer_o(tx_ptr),
    .count_o(tx_cnt),
    .next_pointer_o(tx_nptr),
    .next_count_o(tx_ncnt),
    .end_o(tx_end),
    .empty_o(tx_empty)
  );

  // ------------------------------------------------------------
  // transfer engine
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MEM,
    ST_GAP
  } pdma_state_t;

  pdma_state_t st_reg, st_next;
  pdma_dir_t dir_reg, dir_next;
  logic cyc_reg, cyc_next, we_reg, we_next;
  logic [31:0] adr_reg, adr_next, mdat_reg, mdat_next, txd_reg, txd_next;
  logic rxa_reg, rxa_next, txv_reg, txv_next;
  logic rx_go, tx_go;

  // a request is only served while count is nonzero and the channel is enabled
  assign rx_go = rx_req_i && ctl_reg[CTL_RX_EN] && rx_cnt != RST_COUNT; // see R8
  assign tx_go = tx_req_i && ctl_reg[CTL_TX_EN] && tx_cnt != RST_COUNT; // see R8

  always_comb begin
    st_next = st_reg;
    dir_next = dir_reg;
    cyc_next = cyc_reg;
    we_next = we_reg;
    adr_next = adr_reg;
    mdat_next = mdat_reg;
    txd_next = txd_reg;
    rxa_next = 1'b0;
    txv_next = 1'b0;
    rx_done = 1'b0;
    tx_done = 1'b0;
    case (st_reg)
      ST_IDLE: begin
        // receive first: an overrun loses data, a transmit stall only waits
        if (rx_go) begin
          st_next = ST_MEM;
          dir_next = DIR_RX;
          cyc_next = 1'b1;
          we_next = 1'b1; // see R1
          adr_next = rx_ptr;
          mdat_next = rx_data_i;
        end else if (tx_go) begin
          st_next = ST_MEM;
          dir_next = DIR_TX;
          cyc_next = 1'b1;
          we_next = 1'b0; // see R1
          adr_next = tx_ptr;
        end
      end
      ST_MEM: begin
        if (mem_ack_i) begin
          cyc_next = 1'b0;
          we_next = 1'b0;
          st_next = ST_GAP;
          if (dir_reg == DIR_RX) begin
            rx_done = 1'b1; // see R11
            rxa_next = 1'b1;
          end else begin
            tx_done = 1'b1; // see R11
            txd_next = mem_dat_i;
            txv_next = 1'b1;
          end
        end
      end
      // gap lets the peripheral drop its request after the acknowledge
      ST_GAP: st_next = ST_IDLE;
      default: st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= ST_IDLE;
      dir_reg <= DIR_RX;
      cyc_reg <= 1'b0;
      we_reg <= 1'b0;
      adr_reg <= RST_POINTER;
      mdat_reg <= RST_POINTER;
      txd_reg <= RST_POINTER;
      rxa_reg <= 1'b0;
      txv_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      dir_reg <= dir_next;
      cyc_reg <= cyc_next;
      we_reg <= we_next;
      adr_reg <= adr_next;
      mdat_reg <= mdat_next;
      txd_reg <= txd_next;
      rxa_reg <= rxa_next;
      txv_reg <= txv_next;
    end
  end

  // ------------------------------------------------------------
  // control, status, interrupts
  // ------------------------------------------------------------
  logic endrx_reg, endtx_reg, irq_reg;

  assign ev = {tx_empty, rx_empty, tx_end, rx_end};

  always_comb begin
    ctl_next = ctl_reg;
    imask_next = imask_reg;
    ist_next = ist_reg;
    if (wr_stb && wb_sel_i[0]) begin
      if (wb_adr_i == OFF_CONTROL) ctl_next = wb_dat_i[1:0];
      if (wb_adr_i == OFF_IRQ_MASK) imask_next = wb_dat_i[IRQ_W-1:0];
      if (wb_adr_i == OFF_IRQ_STATUS) ist_next = ist_reg & ~wb_dat_i[IRQ_W-1:0];
    end
    // set wins over a clear in the same cycle
    ist_next = ist_next | ev; // see R9
    ack_next = req;
    rdat_next = 32'h0000_0000;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        OFF_RX_POINTER: rdat_next = rx_ptr;
        OFF_RX_COUNT: rdat_next = {16'h0000, rx_cnt};
        OFF_RX_NEXT_POINTER: rdat_next = rx_nptr;
        OFF_RX_NEXT_COUNT: rdat_next = {16'h0000, rx_ncnt};
        OFF_TX_POINTER: rdat_next = tx_ptr;
        OFF_TX_COUNT: rdat_next = {16'h0000, tx_cnt};
        OFF_TX_NEXT_POINTER: rdat_next = tx_nptr;
        OFF_TX_NEXT_COUNT: rdat_next = {16'h0000, tx_ncnt};
        OFF_CONTROL: rdat_next = {30'h0000_0000, ctl_reg};
        OFF_STATUS: rdat_next = {30'h0000_0000, tx_cnt != RST_COUNT, rx_cnt != RST_COUNT};
        OFF_IRQ_STATUS: rdat_next = {28'h000_0000, ist_reg};
        OFF_IRQ_MASK: rdat_next = {28'h000_0000, imask_reg};
        default: rdat_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_reg <= RST_CONTROL;
      imask_reg <= RST_IRQ;
      ist_reg <= RST_IRQ;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
      endrx_reg <= 1'b0;
      endtx_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ctl_reg <= ctl_next;
      imask_reg <= imask_next;
      ist_reg <= ist_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      endrx_reg <= ist_next[IRQ_END_RX]; // see R9
      endtx_reg <= ist_next[IRQ_END_TX]; // see R9
      irq_reg <= |(ist_next & imask_next);
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign mem_cyc_o = cyc_reg;
  assign mem_we_o = we_reg;
  assign mem_adr_o = adr_reg;
  assign mem_dat_o = mdat_reg;
  assign rx_ack_o = rxa_reg;
  assign tx_data_o = txd_reg;
  assign tx_valid_o = txv_reg;
  assign end_rx_o = endrx_reg;
  assign end_tx_o = endtx_reg;
  assign irq_o = irq_reg;
endmodule

// ### rtl/pdma_pkg.sv
package pdma_pkg;
  // register offsets, byte addresses inside the peripheral window
  localparam logic [8:0] PDMA_BASE = 9'h100;
  localparam logic [8:0] OFF_RX_POINTER = 9'h100;
  localparam logic [8:0] OFF_RX_COUNT = 9'h104;
  localparam logic [8:0] OFF_TX_POINTER = 9'h108;
  localparam logic [8:0] OFF_TX_COUNT = 9'h10C;
  localparam logic [8:0] OFF_RX_NEXT_POINTER = 9'h110;
  localparam logic [8:0] OFF_RX_NEXT_COUNT = 9'h114;
  localparam logic [8:0] OFF_TX_NEXT_POINTER = 9'h118;
  localparam logic [8:0] OFF_TX_NEXT_COUNT = 9'h11C;
  localparam logic [8:0] OFF_CONTROL = 9'h120;
  localparam logic [8:0] OFF_STATUS = 9'h124;
  localparam logic [8:0] OFF_IRQ_STATUS = 9'h128;
  localparam logic [8:0] OFF_IRQ_MASK = 9'h12C;
  // control bits
  localparam int CTL_RX_EN = 0;
  localparam int CTL_TX_EN = 1;
  // interrupt bits
  localparam int IRQ_END_RX = 0;
  localparam int IRQ_END_TX = 1;
  localparam int IRQ_BUF_FULL = 2;
  localparam int IRQ_BUF_EMPTY = 3;
  localparam int IRQ_W = 4;
  // reset values
  localparam logic [31:0] RST_POINTER = 32'h0000_0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [1:0] RST_CONTROL = 2'h0;
  localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;
  // bytes moved per transfer
  localparam logic [31:0] XFER_SIZE = 32'h0000_0004;
  typedef enum logic [1:0] {
    DIR_RX,
    DIR_TX
  } pdma_dir_t;
endpackage

// ### sim/pdma_mem_model.sv
`timescale 1ns/1ps
// ----------------
// memory slave model
// ----------------
module pdma_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic cyc_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic [31:0] wr_adr_o,
  output logic [31:0] wr_dat_o
);
  logic [1:0] wait_reg;
  logic [31:0] junk_reg = 32'h1234_5678;
  // outside an ack the data lines churn, so a stale sample cannot pass
  always_ff @(posedge clk_i) begin
    junk_reg <= junk_reg + 32'h1357_9BDF;
    if (rst_i) begin
      ack_o <= '0;
      wait_reg <= '0;
    end else if (cyc_i && !ack_o && wait_reg >= (slow_i ? 2'h3 : 2'h0)) begin
      ack_o <= 1'h1;
      if (we_i) begin
        wr_adr_o <= adr_i;
        wr_dat_o <= dat_i;
      end
    end else begin
      ack_o <= '0;
      wait_reg <= (cyc_i && !ack_o) ? wait_reg + 2'h1 : 2'h0;
    end
  end
  assign dat_o = ack_o ? adr_i ^ 32'h5A5A_C3C3 : junk_reg;
endmodule

// ### sim/pdma_pair_monitor.sv
`timescale 1ns/1ps
// ----------------
// pair checker
// ----------------
module pdma_pair_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic rx_ack_o,
  input wire logic tx_valid_o,
  input wire logic end_rx_o,
  input wire logic end_tx_o,
  input wire logic mem_cyc_o,
  input wire logic mem_we_o,
  input wire logic [31:0] mem_adr_o,
  input wire logic mem_ack_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("bus ack without request");
  a_mem_held: assert property (mem_cyc_o && !mem_ack_i |=>
    mem_cyc_o && $stable(mem_adr_o) && $stable(mem_we_o))
    else $error("memory request changed before ack");
  a_mem_gap: assert property (mem_cyc_o && mem_ack_i |=> !mem_cyc_o)
    else $error("memory request without gap");
  a_rx_after_write: assert property (rx_ack_o |-> $past(mem_cyc_o && mem_ack_i && mem_we_o))
    else $error("rx ack without memory write");
  a_tx_after_read: assert property (tx_valid_o |-> $past(mem_cyc_o && mem_ack_i && !mem_we_o))
    else $error("tx word without memory read");
  // end flags pass through the sticky status, so they trail the transfer pulse by one cycle
  a_end_rx_ack: assert property ($rose(end_rx_o) |-> $past(rx_ack_o))
    else $error("rx end flag without last transfer");
  a_end_tx_ack: assert property ($rose(end_tx_o) |-> $past(tx_valid_o))
    else $error("tx end flag without last transfer");
  c_rx: cover property (rx_ack_o);
  c_tx: cover property (tx_valid_o);
  c_slow: cover property (mem_cyc_o && !mem_ack_i ##1 mem_cyc_o && !mem_ack_i);
endmodule
bind pdma_pair pdma_pair_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .rx_ack_o(rx_ack_o), .tx_valid_o(tx_valid_o),
  .end_rx_o(end_rx_o), .end_tx_o(end_tx_o), .mem_cyc_o(mem_cyc_o), .mem_we_o(mem_we_o),
  .mem_adr_o(mem_adr_o), .mem_ack_i(mem_ack_i));

// ### sim/tb.sv
`timescale 1ns/1ps
// ----------------
// pair bench
// ----------------
module tb;
  import pdma_pkg::*;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0, rx_req = 1'h0, tx_req = 1'h0, slow = 1'h0;
  logic [8:0] adr = '0;
  logic [31:0] dw = '0, rx_data = '0, dr, tx_data, m_rd, m_adr, m_dw, wr_adr, wr_dat;
  logic ack, rx_ack, tx_valid, end_rx, end_tx, m_cyc, m_we, m_ack, irq;
  logic [31:0] lfsr = 32'h67CC917F, rd, v, p, q;
  int fail_count = 0, comparisons = 0;
  always #2 clk_i = ~clk_i;
  pdma_pair i_pdma_pair (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(dr),
    .wb_ack_o(ack), .rx_req_i(rx_req), .rx_data_i(rx_data), .rx_ack_o(rx_ack),
    .tx_req_i(tx_req), .tx_data_o(tx_data), .tx_valid_o(tx_valid), .end_rx_o(end_rx),
    .end_tx_o(end_tx), .mem_cyc_o(m_cyc), .mem_we_o(m_we), .mem_adr_o(m_adr),
    .mem_dat_o(m_dw), .mem_dat_i(m_rd), .mem_ack_i(m_ack), .irq_o(irq));
  pdma_mem_model i_pdma_mem_model (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .cyc_i(m_cyc),
    .we_i(m_we), .adr_i(m_adr), .dat_i(m_dw), .dat_o(m_rd), .ack_o(m_ack), .wr_adr_o(wr_adr),
    .wr_dat_o(wr_dat));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // word that the memory model returns for a read of address a
  function automatic logic [31:0] mem_word(input logic [31:0] a);
    return a ^ 32'h5A5A_C3C3;
  endfunction
  task automatic final_report();
    $display("compares %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; dw <= d;
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack !== 1'h1 && n < 20);
    if (n >= 20) begin fail_count++; final_report(); end
    rd = dr;
    cyc <= 1'h0; stb <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic xfer(input logic tx, input logic [31:0] a);
    int n;
    v = lfsr; lfsr = nxt(lfsr);
    if (tx) tx_req <= 1'h1;
    else begin rx_req <= 1'h1; rx_data <= v; end
    n = 0;
    do begin @(posedge clk_i); n++; end while ((tx ? tx_valid : rx_ack) !== 1'h1 && n < 40);
    if (n >= 40) begin fail_count++; final_report(); end
    rx_req <= 1'h0; tx_req <= 1'h0;
    if (tx) chk("tx_data", tx_data, mem_word(a));
    else begin chk("mem_adr", wr_adr, a); chk("mem_dat", wr_dat, v); end
    @(posedge clk_i);
  endtask
  task automatic idle_req();
    rx_req <= 1'h1; // held while the channel is disabled or its count is zero, must not reach memory
    repeat (8) begin @(posedge clk_i); chk("mem_cyc idle", {31'h0, m_cyc}, '0); end
    rx_req <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic do_reset();
    rst_i <= 1'h1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
  endtask
  initial begin
    do_reset();
    for (int i = 0; i < 8; i++) begin
      wb(1'h0, OFF_RX_POINTER + 9'(4 * i), '0); chk("reset value", rd, '0);
    end
    wb(1'h0, 9'h1F0, '0); chk("unmapped", rd, '0);
    for (int i = 0; i < 8; i++) begin
      v = lfsr; lfsr = nxt(lfsr);
      wb(1'h1, OFF_RX_POINTER + 9'(4 * i), v);
      wb(1'h0, OFF_RX_POINTER + 9'(4 * i), '0);
      chk("reg rw", rd, i[0] ? {16'h0, v[15:0]} : v);
    end
    $display("test registers done");
    do_reset();
    p = lfsr & 32'hFFFF_FFFC; lfsr = nxt(lfsr); q = lfsr & 32'hFFFF_FFFC;
    wb(1'h1, OFF_RX_POINTER, p); wb(1'h1, OFF_RX_COUNT, 32'h2);
    wb(1'h1, OFF_RX_NEXT_POINTER, q); wb(1'h1, OFF_RX_NEXT_COUNT, 32'h1);
    wb(1'h1, OFF_IRQ_MASK, 32'h1);
    idle_req();
    wb(1'h1, OFF_CONTROL, 32'h1);
    xfer(1'h0, p); xfer(1'h0, p + XFER_SIZE);
    wb(1'h0, OFF_RX_POINTER, '0); chk("reload ptr", rd, q);
    wb(1'h0, OFF_RX_COUNT, '0); chk("reload count", rd, 32'h1);
    wb(1'h0, OFF_RX_NEXT_COUNT, '0); chk("next cleared", rd, '0);
    chk("end_rx", {31'h0, end_rx}, 32'h1); chk("irq", {31'h0, irq}, 32'h1);
    xfer(1'h0, q);
    wb(1'h0, OFF_RX_POINTER, '0); chk("ptr step", rd, q + XFER_SIZE);
    wb(1'h0, OFF_STATUS, '0); chk("rx active", rd & 32'h1, '0);
    idle_req();
    wb(1'h1, OFF_IRQ_STATUS, 32'h1);
    chk("irq cleared", {30'h0, irq, end_rx}, '0);
    $display("test rx done");
    do_reset();
    slow <= 1'h1;
    wb(1'h1, OFF_TX_POINTER, p); wb(1'h1, OFF_TX_COUNT, 32'h2);
    wb(1'h1, OFF_CONTROL, 32'h2);
    xfer(1'h1, p); xfer(1'h1, p + XFER_SIZE);
    wb(1'h0, OFF_TX_COUNT, '0); chk("tx count", rd, '0);
    chk("masked", {30'h0, end_tx, irq}, 32'h2);
    wb(1'h1, OFF_IRQ_MASK, 32'h2); @(posedge clk_i);
    chk("unmasked", {31'h0, irq}, 32'h1);
    wb(1'h0, OFF_IRQ_STATUS, '0); chk("irq status", rd & 32'h3, 32'h2);
    wb(1'h1, OFF_IRQ_STATUS, 32'h2); @(posedge clk_i);
    chk("tx cleared", {30'h0, end_tx, irq}, '0);
    $display("test tx done");
    final_report();
  end
endmodule
